// ### dv/uvs_front.sv
// Model of the measurement front end and blocking matrix.
// Assumes the bench gives wanted magnitudes and block level.
`timescale 1ns/10ps
`default_nettype none
module uvs_front #(parameter int TP = 8) (
	input wire logic clock, // Clock
	input wire logic reset, // Reset
	input wire uvs_pkg::uvs_mag_type mag, // Wanted magnitudes
	input wire uvs_pkg::uvs_src_type src, // Source carrying them
	input wire logic blk, // Wanted block
	output logic tick, // Program-cycle tick
	output logic block_in, // Block to stage
	output uvs_pkg::uvs_sources_type sources // Magnitudes to stage
);
	import uvs_pkg::*;
	int cnt; // Clocks since last tick
	initial begin
		cnt = 0;
		tick = 1'b0;
	end
	// Tick moves on the falling edge, away from sampling
	always @(negedge clock) begin
		cnt <= reset ? 0 : (cnt + 1) % TP;
		tick <= !reset && cnt == TP - 1;
	end
	// Matrix passes the block straight on; the bench moves it off the sampling edge
	always_comb begin
		block_in = blk;
	end
	// Unused sources carry the inverse so a wrong pick shows
	always_comb begin
		sources = {4{~mag}};
		case (src)
			SRC_PHASE_PHASE: sources.phase_phase = mag;
			SRC_PHASE_EARTH: sources.phase_earth = mag;
			SRC_THIRD_INPUT_COMBINED: sources.third_input_combined_source = mag;
			default: sources.fourth_input_single_source = mag;
		endcase
	end
endmodule // uvs_front
`default_nettype wire

// ### dv/uvs_stage_bench.sv
// Self-checking bench of the undervoltage stage.
// Assumes ticks come from the front-end model every eight clocks.
`timescale 1ns/10ps
`default_nettype none
module uvs_stage_bench;
	import uvs_pkg::*;
	logic clock = 1'b0; // 250 MHz clock
	logic reset = 1'b1; // Held five cycles
	logic blk = 1'b0; // Wanted block
	logic tick, block_in, start, trip, blocked, uv_block;
	uvs_mag_type mag = {3{16'h2000}}; // Healthy voltages
	uvs_sources_type sources;
	uvs_general_type general = '{1'b0, FORCE_NORMAL, SRC_PHASE_PHASE};
	uvs_group_type group;
	uvs_info_type info;
	int fails = 0;
	int checks = 0;
	always #2 clock = ~clock;
	uvs_front #(.TP(8)) i_front (.clock, .reset, .mag, .src(general.src_sel), .blk, .tick,
		.block_in, .sources);
	uvs_stage i_dut (.clock, .reset, .tick, .block_in, .sources, .general, .group, .start,
		.trip, .blocked, .uv_block, .info);
	// ==========================================================
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_st(input logic [2:0] exp);
		chk({start, trip, blocked}, exp);
	endtask
	// Wait n ticks, then settle to the falling edge
	task automatic tk(input int n);
		repeat (n) @(posedge clock iff tick);
		@(negedge clock);
	endtask
	task automatic stop_test;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_trip;
		mag = {16'h1f40, 16'h157c, 16'h1f40};
		tk(1);
		chk_st(3'b100);
		chk(info.remaining, 32'h2);
		chk(info.ratio[0], 32'(16'h1f40) * RATIO_SCALE / PICKUP_DEFAULT);
		chk(info.ratio[1], 32'(16'h157c) * RATIO_SCALE / PICKUP_DEFAULT);
		chk(info.ratio[2], 32'(16'h1f40) * RATIO_SCALE / PICKUP_DEFAULT);
		tk(2);
		chk_st(3'b110);
		mag[1] = 16'h1806;
		tk(1);
		chk_st(3'b110);
		mag[1] = 16'h182e;
		tk(1);
		chk_st(3'b000);
	endtask
	task automatic t_blk;
		blk = 1'b1;
		mag[0] = 16'h157c;
		tk(3);
		chk_st(3'b001);
		blk = 1'b0;
		mag[0] = 16'h1f40;
		tk(1);
		chk_st(3'b000);
		mag[0] = 16'h157c;
		tk(1);
		blk = 1'b1;
		repeat (3) @(negedge clock);
		blk = 1'b0;
		tk(1);
		chk_st(3'b100);
		blk = 1'b1;
		tk(3);
		chk({start, trip}, 32'h0);
		blk = 1'b0;
		mag[0] = 16'h1f40;
		tk(1);
	endtask
	task automatic t_rel;
		group.delayed_release = 1'b1;
		group.release_delay = 15'h3;
		mag[0] = 16'h157c;
		tk(1);
		mag[0] = 16'h1f40;
		tk(2);
		chk(start, 32'h1);
		tk(3);
		chk(start, 32'h0);
		group.delayed_release = 1'b0;
	endtask
	task automatic t_uv;
		mag = {3{16'h01f4}};
		tk(4);
		chk({uv_block, trip}, 32'h2);
		mag = {16'h1b58, 16'h1b58, 16'h176f};
		tk(1);
		chk(uv_block, 32'h1);
		mag[0] = 16'h1b58;
		tk(1);
		chk(uv_block, 32'h0);
		group.block_level = '0;
		mag = {3{16'h01f4}};
		tk(3);
		chk({uv_block, trip}, 32'h1);
		mag = {3{16'h1b58}};
		tk(1);
	endtask
	task automatic t_inv;
		group.delay_mode = INVERSE_TIME_MODE;
		mag = {3{16'h0bb8}};
		tk(1);
		repeat (30) @(negedge clock);
		chk(info.expected, DIAL_DEFAULT * DIAL_TICKS * 2);
		mag = '0;
		tk(1);
		repeat (30) @(negedge clock);
		chk(info.expected, DIAL_DEFAULT * DIAL_TICKS);
		mag = {3{16'h1b58}};
		group.delay_mode = FIXED_DELAY_MODE;
		group.block_level = BLOCK_DEFAULT;
		tk(1);
	endtask
	task automatic t_cfg;
		logic [2:0] ex [4] = '{3'b000, 3'b100, 3'b110, 3'b001};
		general.force_sel = FORCE_TRIP;
		repeat (3) @(negedge clock);
		chk_st(3'b000);
		general.force_enable = 1'b1;
		for (int i = 0; i < 4; i++) begin
			general.force_sel = uvs_force_type'(i);
			repeat (2) @(negedge clock);
			chk_st(ex[i]);
		end
		general.force_enable = 1'b0;
		mag = {3{16'h1388}};
		for (int i = 0; i < 4; i++) begin
			general.src_sel = uvs_src_type'(i);
			repeat (2) @(negedge clock);
			chk(info.ratio_min, 32'(16'h1388) * RATIO_SCALE / PICKUP_DEFAULT);
		end
		group.pickup = PICKUP_MAX;
		repeat (2) @(negedge clock);
		chk(info.ratio_min, 32'(16'h1388) * RATIO_SCALE / PICKUP_MAX);
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		group = '{PICKUP_DEFAULT, BLOCK_DEFAULT, FIXED_DELAY_MODE, 19'h2, DIAL_DEFAULT,
			MULT_DEFAULT, RELEASE_DEFAULT_TICKS, 1'b0, 1'b1, 1'b0};
		repeat (5) @(negedge clock);
		reset = 1'b0;
		t_trip;
		t_blk;
		t_rel;
		t_uv;
		t_inv;
		t_cfg;
		stop_test;
	end
	initial begin
		#20000;
		fails++;
		stop_test;
	end
endmodule // uvs_stage_bench
`default_nettype wire

// ### dv/uvs_stage_sva.sv
// Port assertions for the undervoltage stage.
// Assumes the bench holds forcing steady except where it tests forcing.
`timescale 1ns/10ps
`default_nettype none
module uvs_stage_sva (
	input wire logic clock, // Clock
	input wire logic reset, // Reset
	input wire logic tick, // Tick
	input wire logic block_in, // Block input
	input wire uvs_pkg::uvs_sources_type sources, // Magnitudes
	input wire uvs_pkg::uvs_general_type general, // Static settings
	input wire uvs_pkg::uvs_group_type group, // Group settings
	input wire logic start, // START
	input wire logic trip, // TRIP
	input wire logic blocked, // BLOCKED
	input wire logic uv_block, // Low-voltage block
	input wire uvs_pkg::uvs_info_type info // Read-only values
);
	import uvs_pkg::*;
	// ==========================================================
	// Helpers
	uvs_mag_type m; // Selected magnitudes
	logic [15:0] vmin; // Lowest selected magnitude
	logic f1_r, f2_r, r1_r, ok, uv_go, up_ok, hy_ok;
	logic [31:0] rm; // Expected lowest ratio
	// Pick the selected source and its lowest voltage
	always_comb begin
		case (general.src_sel)
			SRC_PHASE_EARTH: m = sources.phase_earth;
			SRC_THIRD_INPUT_COMBINED: m = sources.third_input_combined_source;
			SRC_FOURTH_INPUT_SINGLE: m = sources.fourth_input_single_source;
			default: m = sources.phase_phase;
		endcase
		vmin = m[0] < m[1] ? m[0] : m[1];
		vmin = m[2] < vmin ? m[2] : vmin;
	end
	// Forcing and reset history, so their edges are not judged
	always_ff @(posedge clock) begin
		f1_r <= general.force_enable;
		f2_r <= f1_r;
		r1_r <= reset;
	end
	assign ok = !(general.force_enable | f1_r | f2_r | r1_r);
	assign uv_go = tick && group.block_level != '0 && vmin < group.block_level;
	assign up_ok = vmin > group.pickup;
	assign hy_ok = 32'(vmin) > 32'(group.pickup) * RESET_RATIO_PCT / 100;
	assign rm = 32'(vmin) * RATIO_SCALE / group.pickup;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// ==========================================================
	// Assertions
	chk_status_tick: assert property (ok && $changed({start, trip, blocked, uv_block})
		|-> $past(tick)) else $error("status moved off tick");
	chk_trip_uvblk: assert property (ok && uv_block |-> !trip)
		else $error("trip while low block");
	chk_start_excl: assert property (ok |-> !(start && blocked))
		else $error("start with blocked");
	chk_force_trip: assert property (general.force_enable && general.force_sel == FORCE_TRIP
		|=> trip && start) else $error("forced trip missing");
	chk_block_drop: assert property (ok && tick && block_in && !group.delayed_release
		|=> !start && !trip) else $error("start kept under block");
	chk_uvblk_set: assert property (ok && $rose(uv_block) |-> $past(uv_go))
		else $error("low block without cause");
	chk_uvblk_hold: assert property (ok && $fell(uv_block) |-> $past(tick)
		&& ($past(up_ok) || $past(group.block_level) == '0))
		else $error("low block left early");
	chk_release_hyst: assert property (ok && $fell(start) && !group.delayed_release
		|-> $past(block_in) || $past(hy_ok)) else $error("release below reset level");
	chk_ratio_min: assert property (!r1_r |-> info.ratio_min == RATIO_W'($past(rm)))
		else $error("lowest ratio wrong");
	cover property (start && !trip);
	cover property (trip && !general.force_enable);
	cover property (blocked && !start);
	cover property (uv_block && start && !trip);
endmodule // uvs_stage_sva
bind uvs_stage uvs_stage_sva i_sva (.clock, .reset, .tick, .block_in, .sources, .general,
	.group, .start, .trip, .blocked, .uv_block, .info);
`default_nettype wire

// ### logic/uvs_pkg.sv
// Shared constants and types of the undervoltage stage.
// Assumes one system clock and a program-cycle tick made by logic on that clock.
//
// How it works
// - Forced status honoured only under global forcing enable
// - Magnitudes come from one of four sources
// - Forcing and source are static, not group settings
// - Ratio of each voltage to pick-up computed continuously
// - Pick-up releases above 103 percent of level
// - One common level, any voltage below starts pick-up
// - Pick-up level 20.00 to 120.00 percent, default 60
// - Block level 0 to 100 percent, zero disables
// - No trip below low-voltage block level
// - Low-voltage block holds until all above pick-up
// - Setting group may change while running
// - Expected operating time reported, tracks voltage when inverse
// - Remaining time to trip reported while counting
// - Lowest voltage ratio reported with 0.01 resolution
// - Block input sampled once each program cycle
// - Block input is a dedicated port from matrix
// - Pick-up without block gives START and timing
// - Pick-up with block gives BLOCKED, no timing
// - Block during START drops it into release handling
// - Inverse time is dial over one minus ratio power
// - Delayed release holds START for release delay
package uvs_pkg;

	// ==========================================================
	// Widths and scaling
	localparam int MAG_W = 16;                     // Magnitude in 0.01 %Un steps
	localparam int RATIO_W = 18;                   // Ratio in 0.01 steps
	localparam int TIME_W = 19;                    // Times in program-cycle ticks
	localparam int RATIO_SCALE = 100;              // 0.01 resolution of ratios
	localparam int RESET_RATIO_PCT = 103;          // Pick-up release level in percent
	localparam logic [16:0] Q16_ONE = 17'h10000;   // 1.0 in Q16

	// ==========================================================
	// Timing
	localparam int PROG_CYCLE_US = 5000;           // One program-cycle tick
	localparam int DIAL_STEP_US = 10000;           // Time dial step
	localparam int DIAL_TICKS = DIAL_STEP_US / PROG_CYCLE_US;
	localparam int TIME_MAX_S = 1800;              // Longest reported time
	localparam logic [TIME_W-1:0] TIME_MAX_TICKS = TIME_W'(TIME_MAX_S * 1000000 / PROG_CYCLE_US);
	localparam int BLOCK_MARGIN_MS = 5;            // Block lead time the source must keep
	localparam int EXP_ROUND = 50;                 // Rounds multiplier to whole exponent

	// ==========================================================
	// Setting reset values
	localparam logic [MAG_W-1:0] PICKUP_DEFAULT = 16'h1770;      // 60.00 %Un
	localparam logic [MAG_W-1:0] PICKUP_MIN = 16'h07d0;          // 20.00 %Un
	localparam logic [MAG_W-1:0] PICKUP_MAX = 16'h2ee0;          // 120.00 %Un
	localparam logic [MAG_W-1:0] BLOCK_DEFAULT = 16'h03e8;       // 10.00 %Un
	localparam logic [MAG_W-1:0] BLOCK_MAX = 16'h2710;           // 100.00 %Un
	localparam int DT_DEFAULT_MS = 40;
	localparam logic [TIME_W-1:0] DT_DEFAULT_TICKS = TIME_W'(DT_DEFAULT_MS * 1000 / PROG_CYCLE_US);
	localparam int RELEASE_DEFAULT_MS = 60;
	localparam logic [14:0] RELEASE_DEFAULT_TICKS = 15'(RELEASE_DEFAULT_MS * 1000 / PROG_CYCLE_US);
	localparam logic [12:0] DIAL_DEFAULT = 13'h0005;             // 0.05 s
	localparam logic [11:0] MULT_DEFAULT = 12'h064;              // 1.00

	// ==========================================================
	// Enumerations
	typedef enum logic [1:0] {FORCE_NORMAL, FORCE_START, FORCE_TRIP, FORCE_BLOCKED} uvs_force_type;
	typedef enum logic [1:0] {SRC_PHASE_PHASE, SRC_PHASE_EARTH, SRC_THIRD_INPUT_COMBINED,
		SRC_FOURTH_INPUT_SINGLE} uvs_src_type;
	typedef enum logic {FIXED_DELAY_MODE, INVERSE_TIME_MODE} uvs_delay_type;
	typedef enum logic [2:0] {ST_IDLE, ST_STARTED, ST_RELEASING, ST_TRIPPED, ST_BLOCKED} uvs_stage_type;

	// ==========================================================
	// Carriers
	typedef logic [2:0][MAG_W-1:0] uvs_mag_type;            // Three measured magnitudes
	typedef struct packed {
		uvs_mag_type phase_phase;
		uvs_mag_type phase_earth;
		uvs_mag_type third_input_combined_source;
		uvs_mag_type fourth_input_single_source;
	} uvs_sources_type;
	typedef struct packed {
		logic force_enable;            // Global stage-forcing enable
		uvs_force_type force_sel;      // Forced status
		uvs_src_type src_sel;          // Measured magnitude source
	} uvs_general_type;
	typedef struct packed {
		logic [MAG_W-1:0] pickup;      // Pick-up level, 0.01 %Un
		logic [MAG_W-1:0] block_level; // Low-voltage block level, 0.01 %Un
		uvs_delay_type delay_mode;
		logic [TIME_W-1:0] dt_delay;   // Fixed delay in ticks
		logic [12:0] dial;             // Time dial, 0.01 s
		logic [11:0] mult;             // Inverse-time exponent, 0.01
		logic [14:0] release_delay;    // Release delay in ticks
		logic delayed_release;
		logic reset_after_release;
		logic continue_calc;
	} uvs_group_type;
	typedef struct packed {
		logic start;
		logic trip;
		logic blocked;
		logic uv_block;
	} uvs_status_type;
	typedef struct packed {
		logic [2:0][RATIO_W-1:0] ratio;      // Per-voltage ratio
		logic [RATIO_W-1:0] ratio_min;       // Lowest voltage ratio
		logic [TIME_W-1:0] expected;         // Expected operating time, ticks
		logic signed [TIME_W:0] remaining;   // Time left to trip, ticks
	} uvs_info_type;
	typedef struct packed {
		uvs_stage_type stage;
		logic pickup;
		logic blk;
		logic uv_block;
		logic [TIME_W-1:0] elapsed;
		logic [14:0] rel_cnt;
		logic [4:0] pow_cnt;
		logic [16:0] pow;
		uvs_status_type status;
		uvs_info_type info;
	} uvs_state_type;

endpackage

// ### logic/uvs_stage.sv
// Undervoltage protection stage: pick-up, low-voltage block, timers and status.
// Assumes measured magnitudes, block input and tick come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none

module uvs_stage (
	input wire logic clock,                        // System clock, 250 MHz
	input wire logic reset,                        // Synchronous reset, active high
	input wire logic tick,                         // Program-cycle tick, one cycle
	input wire logic block_in,                     // Blocking matrix input
	input wire uvs_pkg::uvs_sources_type sources,  // All measured magnitudes
	input wire uvs_pkg::uvs_general_type general,  // Static configuration
	input wire uvs_pkg::uvs_group_type group,      // Active setting group
	output logic start,                            // START output
	output logic trip,                             // TRIP output
	output logic blocked,                          // BLOCKED output
	output logic uv_block,                         // Low-voltage block engaged
	output uvs_pkg::uvs_info_type info             // Read-only values
);
	import uvs_pkg::*;

	// ==========================================================
	// State
	uvs_state_type st_r;        // Whole state
	uvs_state_type st_nxt;      // Next state

	// ==========================================================
	// Helpers
	// Saturating increment of a tick count
	function automatic logic [TIME_W-1:0] sat_inc(input logic [TIME_W-1:0] v);
		sat_inc = (v >= TIME_MAX_TICKS) ? TIME_MAX_TICKS : v + 1'b1;
	endfunction

	// Magnitude over pick-up in 0.01 steps
	function automatic logic [RATIO_W-1:0] ratio_of(input logic [MAG_W-1:0] m,
		input logic [MAG_W-1:0] p);
		logic [31:0] q;
		q = (32'(m) * RATIO_SCALE) / ((p == '0) ? 32'h1 : 32'(p));
		ratio_of = q[RATIO_W-1:0];
	endfunction

	// Keeps a setting inside its legal range, so a stray value cannot stall the stage
	function automatic logic [MAG_W-1:0] clamp_mag(input logic [MAG_W-1:0] v,
		input logic [MAG_W-1:0] lo, input logic [MAG_W-1:0] hi);
		if (v < lo) begin
			clamp_mag = lo; // Below range
		end else if (v > hi) begin
			clamp_mag = hi; // Above range
		end else begin
			clamp_mag = v; // In range
		end
	endfunction

	// Stage states in which the operating timer is counting
	function automatic logic is_counting(input uvs_stage_type s);
		is_counting = (s == ST_STARTED) || (s == ST_RELEASING);
	endfunction

	// Combinational working values
	uvs_mag_type mag;            // Selected magnitudes
	logic [MAG_W-1:0] vmin;      // Lowest magnitude
	logic [16:0] reset_lvl;      // 103 % of pick-up
	logic [31:0] r_full;         // Lowest over pick-up, Q16
	logic [15:0] r_q16;          // Clipped below 1.0
	logic [4:0] exp_int;         // Whole exponent
	logic [11:0] mult_rnd;       // Rounded multiplier
	logic [31:0] inverse_time_mode_num;       // Dial ticks in Q16
	logic [16:0] inverse_time_mode_den;       // One minus power
	logic [31:0] inverse_time_mode_q;         // Inverse-time result
	logic [TIME_W-1:0] exp_now;  // Expected time this cycle
	logic [33:0] prod;           // Power step product
	logic pk;                    // Pick-up after hysteresis
	logic uvb;                   // Low-voltage block after update
	logic go_release;            // Start release handling
	logic [MAG_W-1:0] pu;        // Pick-up level held in its legal range
	logic [MAG_W-1:0] blk_lvl;   // Block level held in its legal range

	// ==========================================================
	// Next-state logic
	always_comb begin
		st_nxt = st_r;
		mag = '0;
		vmin = '0;
		reset_lvl = '0;
		r_full = '0;
		r_q16 = '0;
		exp_int = '0;
		mult_rnd = '0;
		inverse_time_mode_num = '0;
		inverse_time_mode_den = '0;
		inverse_time_mode_q = '0;
		exp_now = '0;
		prod = '0;
		pk = st_r.pickup;
		uvb = st_r.uv_block;
		go_release = 1'b0;
		// Settings held inside their legal ranges
		pu = clamp_mag(group.pickup, PICKUP_MIN, PICKUP_MAX);
		blk_lvl = clamp_mag(group.block_level, '0, BLOCK_MAX);

		// Source selection from static settings
		case (general.src_sel)
			SRC_PHASE_PHASE: mag = sources.phase_phase;
			SRC_PHASE_EARTH: mag = sources.phase_earth;
			SRC_THIRD_INPUT_COMBINED: mag = sources.third_input_combined_source;
			SRC_FOURTH_INPUT_SINGLE: mag = sources.fourth_input_single_source;
			default: mag = sources.phase_phase;
		endcase

		// Lowest magnitude and ratios, every clock
		vmin = mag[0];
		for (int i = 0; i < 3; i++) begin
			st_nxt.info.ratio[i] = ratio_of(mag[i], pu);
			if (mag[i] < vmin) begin
				vmin = mag[i];
			end
		end
		st_nxt.info.ratio_min = ratio_of(vmin, pu);
		reset_lvl = 17'((32'(pu) * RESET_RATIO_PCT) / 100);

		// Inverse time: ratio power by repeated multiply
		r_full = (32'(vmin) << 16) / ((pu == '0) ? 32'h1 : 32'(pu));
		r_q16 = (r_full > 32'h0000ffff) ? 16'hffff : r_full[15:0];
		mult_rnd = 12'((32'(group.mult) + EXP_ROUND) / RATIO_SCALE);
		exp_int = (mult_rnd == '0) ? 5'h1 : mult_rnd[4:0];
		if (st_r.pow_cnt != '0) begin
			prod = 34'(st_r.pow) * 34'(r_q16);
			st_nxt.pow = prod[32:16];
			st_nxt.pow_cnt = st_r.pow_cnt - 1'b1;
		end
		inverse_time_mode_num = (32'(group.dial) * DIAL_TICKS) << 16;
		inverse_time_mode_den = Q16_ONE - st_r.pow;
		inverse_time_mode_q = (inverse_time_mode_den == '0) ? 32'(TIME_MAX_TICKS) : inverse_time_mode_num / 32'(inverse_time_mode_den);
		if (group.delay_mode == INVERSE_TIME_MODE) begin
			exp_now = (inverse_time_mode_q > 32'(TIME_MAX_TICKS)) ? TIME_MAX_TICKS : inverse_time_mode_q[TIME_W-1:0];
		end else begin
			exp_now = group.dt_delay;
		end
		if (st_r.pow_cnt == '0) begin
			st_nxt.info.expected = exp_now;
		end

		// Program-cycle evaluation
		if (tick) begin
			st_nxt.blk = block_in;
			st_nxt.pow = Q16_ONE;
			st_nxt.pow_cnt = exp_int;
			// Pick-up with 103 % release hysteresis
			if (st_r.pickup) begin
				pk = !(17'(vmin) > reset_lvl);
			end else begin
				pk = vmin < pu;
			end
			st_nxt.pickup = pk;
			// Low-voltage block, zero level disables
			if (blk_lvl == '0) begin
				uvb = 1'b0;
			end else if (vmin < blk_lvl) begin
				uvb = 1'b1;
			end else if (vmin > pu) begin
				uvb = 1'b0;
			end
			st_nxt.uv_block = uvb;

			// Stage transitions
			case (st_r.stage)
				// Waiting for a pick-up
				ST_IDLE: begin
					if (pk && block_in) begin
						st_nxt.stage = ST_BLOCKED;
					end else if (pk) begin
						st_nxt.elapsed = '0;
						if (st_r.info.expected == '0 && !uvb) begin
							st_nxt.stage = ST_TRIPPED;
						end else begin
							st_nxt.stage = ST_STARTED;
						end
					end
				end
				// Timing toward a trip
				ST_STARTED: begin
					if (!pk || block_in) begin
						go_release = 1'b1;
					end else begin
						st_nxt.elapsed = sat_inc(st_r.elapsed);
						// Expired timer waits while the low-voltage block holds
						if (st_nxt.elapsed >= st_r.info.expected && !uvb) begin
							st_nxt.stage = ST_TRIPPED;
						end
					end
				end
				// Holding START after the pick-up dropped or a block came
				ST_RELEASING: begin
					if (pk && !block_in) begin
						st_nxt.stage = ST_STARTED;
					end else begin
						st_nxt.rel_cnt = st_r.rel_cnt + 1'b1;
						if (group.continue_calc) begin
							st_nxt.elapsed = sat_inc(st_r.elapsed);
						end
						if (st_nxt.rel_cnt >= group.release_delay) begin
							st_nxt.stage = ST_IDLE;
							st_nxt.elapsed = '0;
						end
					end
				end
				// Trip issued, waiting for recovery or block
				ST_TRIPPED: begin
					if (!pk || block_in) begin
						st_nxt.stage = ST_IDLE;
						st_nxt.elapsed = '0;
					end
				end
				// Pick-up met an active block
				ST_BLOCKED: begin
					if (!pk || !block_in) begin
						st_nxt.stage = ST_IDLE;
					end
				end
				default: st_nxt.stage = ST_IDLE;
			endcase

			// Release handling shared by pick-up drop and block
			if (go_release) begin
				st_nxt.rel_cnt = '0;
				// Hold START through the release delay, or drop at once
				if (group.delayed_release) begin
					st_nxt.stage = ST_RELEASING;
					if (!group.reset_after_release) begin
						st_nxt.elapsed = '0;
					end
				end else begin
					st_nxt.stage = ST_IDLE;
					st_nxt.elapsed = '0;
				end
			end
		end

		// Remaining time while counting
		if (is_counting(st_nxt.stage)) begin
			st_nxt.info.remaining = $signed({1'b0, st_nxt.info.expected})
				- $signed({1'b0, st_nxt.elapsed});
		end else begin
			st_nxt.info.remaining = '0;
		end

		// Status outputs, forcing overrides when globally enabled
		st_nxt.status.uv_block = st_nxt.uv_block;
		st_nxt.status.start = is_counting(st_nxt.stage) || (st_nxt.stage == ST_TRIPPED);
		st_nxt.status.trip = (st_nxt.stage == ST_TRIPPED) && !st_nxt.uv_block;
		st_nxt.status.blocked = st_nxt.stage == ST_BLOCKED;
		// Forcing replaces the computed START, TRIP and BLOCKED; uv_block is kept
		if (general.force_enable) begin
			case (general.force_sel)
				FORCE_NORMAL: begin
					st_nxt.status.start = 1'b0;
					st_nxt.status.trip = 1'b0;
					st_nxt.status.blocked = 1'b0;
				end
				FORCE_START: begin
					st_nxt.status.start = 1'b1;
					st_nxt.status.trip = 1'b0;
					st_nxt.status.blocked = 1'b0;
				end
				FORCE_TRIP: begin
					st_nxt.status.start = 1'b1;
					st_nxt.status.trip = 1'b1;
					st_nxt.status.blocked = 1'b0;
				end
				default: begin
					st_nxt.status.start = 1'b0;
					st_nxt.status.trip = 1'b0;
					st_nxt.status.blocked = 1'b1;
				end
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clock) begin
		if (reset) begin
			// Reset leaves the stage idle with a neutral power
			st_r <= '0;
			st_r.stage <= ST_IDLE;
			st_r.pow <= Q16_ONE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs
	// Every output comes straight from the state register
	assign start = st_r.status.start;
	assign trip = st_r.status.trip;
	assign blocked = st_r.status.blocked;
	assign uv_block = st_r.status.uv_block;
	assign info = st_r.info;

endmodule // uvs_stage

`default_nettype wire
